// ### shared/sra_defines.vh
`ifndef SRA_DEFINES_VH
`define SRA_DEFINES_VH

// ----------------------------------------
// Register offsets and control fields
// ----------------------------------------
`define SRA_REG_CTRL 8'h00
`define SRA_REG_BLKSEL 8'h04
`define SRA_REG_INT_STAT 8'h08
`define SRA_REG_INT_MASK 8'h0c
`define SRA_REG_REC_LEN 8'h10
`define SRA_CTRL_REQ 0
`define SRA_CTRL_GEO 1
`define SRA_BLKSEL_RST 11'h7ff
`define SRA_INT_MASK_RST 3'h0
`define SRA_EV_REC 0
`define SRA_EV_GEO 1
`define SRA_EV_REFUSED 2

// ----------------------------------------
// Header word fields
// ----------------------------------------
`define SRA_HDR_FORCED 15
`define SRA_HDR_GEN 10
`define SRA_HDR_RSV 9
`define SRA_HDR_PLN 8

// ----------------------------------------
// General status byte and axis switch byte
// ----------------------------------------
`define SRA_GEN_PROG 7
`define SRA_GEN_WAIT 2
`define SRA_GEN_TRACE 1
`define SRA_GEN_ECHO 0
`define SRA_SW_LATCHED 7
`define SRA_SW_LATCH_IN 6
`define SRA_SW_REV_LIM 2
`define SRA_SW_HOME 1
`define SRA_SW_STEP_JMP 0

// ----------------------------------------
// Axis status word and plane status word
// ----------------------------------------
`define SRA_ST_MOVE 15
`define SRA_ST_ABS_REL 14
`define SRA_ST_ABS_ONLY 13
`define SRA_ST_EDGE 12
`define SRA_ST_HOMING 11
`define SRA_ST_HOME1 10
`define SRA_ST_HOME2 9
`define SRA_ST_COORD 8
`define SRA_ST_NEG 7
`define SRA_ST_CONTOUR 6
`define SRA_ST_SLEW 5
`define SRA_ST_STOP 4
`define SRA_ST_DECEL 3
`define SRA_ST_LARMED 2
`define SRA_ST_OOE 1
`define SRA_ST_MOFF 0
`define SRA_PL_MOVE 15
`define SRA_PL_SLEW 5
`define SRA_PL_STOP 4
`define SRA_PL_DECEL 3

// ----------------------------------------
// Scaling, limits and block sizes
// ----------------------------------------
`define SRA_VEL_SHIFT 6
`define SRA_TORQUE_MAX 18'sd32767
`define SRA_TORQUE_MIN -18'sd32767
`define SRA_HDR_BYTES 4'd4
`define SRA_GEN_BYTES 4'd1
`define SRA_RSV_BYTES 4'd8
`define SRA_PLN_BYTES 4'd2
`define SRA_AXIS_BYTES 4'd9
`define SRA_GEO_BYTES 4'd4

`endif

// ### verilog/sra_irq.v
`timescale 1ns/100ps
`include "sra_defines.vh"

module sra_irq #(
   parameter W = 3
) (
   input wire clk,
   input wire rst,
   input wire [W-1:0] evt,
   input wire mask_wr,
   input wire [W-1:0] mask_data,
   input wire stat_rd,
   output reg [W-1:0] stat_reg,
   output reg [W-1:0] mask_reg,
   output reg irq_reg
);

   wire [W-1:0] stat_next;
   wire [W-1:0] mask_next;

   // A read clears the sticky bits, but an event in the same cycle survives.
   assign stat_next = (stat_rd ? {W{1'b0}} : stat_reg) | evt;
   assign mask_next = mask_wr ? mask_data : mask_reg;

   // Status, mask and the level interrupt are all registered.
   always @(posedge clk) begin
      if (rst) begin
         stat_reg <= {W{1'b0}};
         mask_reg <= `SRA_INT_MASK_RST;
         irq_reg <= 1'b0;
      end else begin
         stat_reg <= stat_next;
         mask_reg <= mask_next;
         irq_reg <= |(stat_next & mask_next);
      end
   end

endmodule

// ### verilog/sra_axis_pack.v
`timescale 1ns/100ps
`include "sra_defines.vh"

module sra_axis_pack (
   input wire clk,
   input wire rst,
   input wire [15:0] status_word,
   input wire latched,
   input wire latch_pin,
   input wire rev_pin,
   input wire home_pin,
   input wire jumper_pin,
   input wire [31:0] vel_query,
   input wire [17:0] torque_raw,
   output wire [71:0] block
);

   reg [3:0] pin_s1_reg;
   reg [3:0] pin_s2_reg;
   wire [7:0] sw_byte;
   wire [31:0] vel_rec;
   wire signed [17:0] tq;
   wire signed [17:0] tq_sel;

   // Switch pins come from outside the clock domain, so two flops first.
   always @(posedge clk) begin
      if (rst) begin
         pin_s1_reg <= 4'h0;
         pin_s2_reg <= 4'h0;
      end else begin
         pin_s1_reg <= {latch_pin, rev_pin, home_pin, jumper_pin};
         pin_s2_reg <= pin_s1_reg;
      end
   end

   assign sw_byte = (latched << `SRA_SW_LATCHED) | (pin_s2_reg[3] << `SRA_SW_LATCH_IN)
                  | (pin_s2_reg[2] << `SRA_SW_REV_LIM) | (pin_s2_reg[1] << `SRA_SW_HOME)
                  | (pin_s2_reg[0] << `SRA_SW_STEP_JMP);

   assign vel_rec = {vel_query[31-`SRA_VEL_SHIFT:0], {`SRA_VEL_SHIFT{1'b0}}};

   assign tq = torque_raw;
   assign tq_sel = (tq > `SRA_TORQUE_MAX) ? `SRA_TORQUE_MAX : (tq < `SRA_TORQUE_MIN) ? `SRA_TORQUE_MIN : tq;

   assign block = {tq_sel[15:0], vel_rec, sw_byte, status_word};

endmodule

// ### verilog/sra_top.v
`timescale 1ns/100ps
`include "sra_defines.vh"

module sra_top #(
   parameter NUM_AXES = 8
) (
   input wire SYS_CLK,
   input wire RST,
   input wire [7:0] ADDR,
   input wire [31:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [31:0] RDATA,
   output reg [7:0] REC_DATA,
   output reg REC_VALID,
   output reg REC_LAST,
   input wire REC_READY,
   output wire IRQ,
   input wire PROG_RUN,
   input wire WAIT_INPUT,
   input wire TRACE_ON,
   input wire ECHO_ON,
   input wire VEC_MOVE,
   input wire VEC_SLEW,
   input wire VEC_STOP,
   input wire VEC_DECEL,
   input wire [7:0] AX_MOVE,
   input wire [7:0] AX_ABS_REL,
   input wire [7:0] AX_ABS_ONLY,
   input wire [7:0] AX_EDGE_SEARCH,
   input wire [7:0] AX_HOMING,
   input wire [7:0] AX_HOME_PH1,
   input wire [7:0] AX_HOME_PH2,
   input wire [7:0] AX_COORD,
   input wire [7:0] AX_NEG_DIR,
   input wire [7:0] AX_CONTOUR,
   input wire [7:0] AX_SLEW,
   input wire [7:0] AX_STOPPING,
   input wire [7:0] AX_DECEL,
   input wire [7:0] AX_LATCH_ARMED,
   input wire [7:0] AX_OFF_ON_ERR,
   input wire [7:0] AX_MOTOR_OFF,
   input wire [7:0] AX_LATCHED,
   input wire [7:0] AX_LATCH_IN,
   input wire [7:0] AX_REV_LIMIT,
   input wire [7:0] AX_HOME_IN,
   input wire [7:0] AX_STEP_JUMPER,
   input wire [255:0] AX_VEL,
   input wire [143:0] AX_TORQUE
);

   // ----------------------------------------
   // Segment states and constants
   // ----------------------------------------
   localparam S_IDLE = 3'd0;
   localparam S_HDR = 3'd1;
   localparam S_GEN = 3'd2;
   localparam S_TBL = 3'd3;
   localparam S_PLN = 3'd4;
   localparam S_AXS = 3'd5;
   localparam S_GEO = 3'd6;
   localparam [7:0] AXIS_MASK = 8'hff >> (8 - NUM_AXES);
   localparam [3:0] NO_AXIS = 4'd8;

   reg [2:0] seg_reg;
   reg [3:0] idx_reg;
   reg [3:0] ax_reg;
   reg [10:0] blksel_reg;
   reg [15:0] hdr_reg;
   reg [15:0] len_reg;
   reg [2:0] seg_after;
   reg [3:0] ax_after;
   reg [7:0] cur_byte;
   wire [15:0] st_w [0:7];
   wire [71:0] blk_w [0:7];
   wire [7:0] gen_byte;
   wire [15:0] pln_word;
   wire [10:0] flags_now;
   wire busy;
   wire load;
   wire seg_last;
   wire final_byte;
   wire req_wr;
   wire geo_wr;
   wire [2:0] evt;
   wire [2:0] int_stat;
   wire [2:0] int_mask;

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------

   // Lowest flagged axis at or above a start index, or none.
   function [3:0] next_axis;
      input [7:0] m;
      input [3:0] from;
      integer i;
      begin
         next_axis = NO_AXIS;
         for (i = 7; i >= 0; i = i - 1) begin
            if (m[i] && i >= from) begin
               next_axis = i[3:0];
            end
         end
      end
   endfunction

   // First flagged block after the current one.
   function [2:0] next_seg;
      input [2:0] cur;
      input [10:0] f;
      begin
         if (cur < S_GEN && f[`SRA_HDR_GEN]) begin
            next_seg = S_GEN;
         end else if (cur < S_TBL && f[`SRA_HDR_RSV]) begin
            next_seg = S_TBL;
         end else if (cur < S_PLN && f[`SRA_HDR_PLN]) begin
            next_seg = S_PLN;
         end else if (|f[7:0]) begin
            next_seg = S_AXS;
         end else begin
            next_seg = S_IDLE;
         end
      end
   endfunction

   // Byte count of one segment.
   function [3:0] seg_len;
      input [2:0] s;
      begin
         case (s)
            S_HDR: seg_len = `SRA_HDR_BYTES;
            S_GEN: seg_len = `SRA_GEN_BYTES;
            S_TBL: seg_len = `SRA_RSV_BYTES;
            S_PLN: seg_len = `SRA_PLN_BYTES;
            S_AXS: seg_len = `SRA_AXIS_BYTES;
            S_GEO: seg_len = `SRA_GEO_BYTES;
            default: seg_len = 4'd1;
         endcase
      end
   endfunction

   // Whole record length, header included, for a set of flags.
   function [15:0] rec_len;
      input [10:0] f;
      integer i;
      begin
         rec_len = {12'h000, `SRA_HDR_BYTES};
         if (f[`SRA_HDR_GEN]) rec_len = rec_len + {12'h000, `SRA_GEN_BYTES};
         if (f[`SRA_HDR_RSV]) rec_len = rec_len + {12'h000, `SRA_RSV_BYTES};
         if (f[`SRA_HDR_PLN]) rec_len = rec_len + {12'h000, `SRA_PLN_BYTES};
         for (i = 0; i < 8; i = i + 1) begin
            if (f[i]) rec_len = rec_len + {12'h000, `SRA_AXIS_BYTES};
         end
      end
   endfunction

   // ----------------------------------------
   // Status word assembly
   // ----------------------------------------

   assign gen_byte = (PROG_RUN << `SRA_GEN_PROG) | (WAIT_INPUT << `SRA_GEN_WAIT)
                   | (TRACE_ON << `SRA_GEN_TRACE) | (ECHO_ON << `SRA_GEN_ECHO);

   assign pln_word = (VEC_MOVE << `SRA_PL_MOVE) | (VEC_SLEW << `SRA_PL_SLEW)
                   | (VEC_STOP << `SRA_PL_STOP) | (VEC_DECEL << `SRA_PL_DECEL);

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : axis
         assign st_w[g][`SRA_ST_MOVE] = AX_MOVE[g];
         assign st_w[g][`SRA_ST_ABS_REL] = AX_ABS_REL[g];
         assign st_w[g][`SRA_ST_ABS_ONLY] = AX_ABS_ONLY[g];
         assign st_w[g][`SRA_ST_EDGE] = AX_EDGE_SEARCH[g];
         assign st_w[g][`SRA_ST_HOMING] = AX_HOMING[g];
         assign st_w[g][`SRA_ST_HOME1] = AX_HOME_PH1[g];
         assign st_w[g][`SRA_ST_HOME2] = AX_HOME_PH2[g];
         assign st_w[g][`SRA_ST_COORD] = AX_COORD[g];
         assign st_w[g][`SRA_ST_NEG] = AX_NEG_DIR[g];
         assign st_w[g][`SRA_ST_CONTOUR] = AX_CONTOUR[g];
         assign st_w[g][`SRA_ST_SLEW] = AX_SLEW[g];
         assign st_w[g][`SRA_ST_STOP] = AX_STOPPING[g];
         assign st_w[g][`SRA_ST_DECEL] = AX_DECEL[g];
         assign st_w[g][`SRA_ST_LARMED] = AX_LATCH_ARMED[g];
         assign st_w[g][`SRA_ST_OOE] = AX_OFF_ON_ERR[g];
         assign st_w[g][`SRA_ST_MOFF] = AX_MOTOR_OFF[g];

         // Each axis block is packed from its own fields.
         sra_axis_pack u_pack (
            .clk(SYS_CLK),
            .rst(RST),
            .status_word(st_w[g]),
            .latched(AX_LATCHED[g]),
            .latch_pin(AX_LATCH_IN[g]),
            .rev_pin(AX_REV_LIMIT[g]),
            .home_pin(AX_HOME_IN[g]),
            .jumper_pin(AX_STEP_JUMPER[g]),
            .vel_query(AX_VEL[g*32 +: 32]),
            .torque_raw(AX_TORQUE[g*18 +: 18]),
            .block(blk_w[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // Register bus
   // ----------------------------------------

   // Flags a request would carry: axes beyond the fitted count never appear.
   assign flags_now = {blksel_reg[10:8], blksel_reg[7:0] & AXIS_MASK};
   assign req_wr = WR && ADDR == `SRA_REG_CTRL && WDATA[`SRA_CTRL_REQ];
   assign geo_wr = WR && ADDR == `SRA_REG_CTRL && WDATA[`SRA_CTRL_GEO];

   // Block select register steers which blocks the next record holds.
   always @(posedge SYS_CLK) begin
      if (RST) begin
         blksel_reg <= `SRA_BLKSEL_RST;
      end else if (WR && ADDR == `SRA_REG_BLKSEL) begin
         blksel_reg <= WDATA[10:0];
      end
   end

   // Read data stand in the cycle after the strobe only.
   always @(posedge SYS_CLK) begin
      if (RST) begin
         RDATA <= 32'h0000_0000;
      end else if (RD) begin
         case (ADDR)
            `SRA_REG_CTRL: RDATA <= {31'h0000_0000, busy};
            `SRA_REG_BLKSEL: RDATA <= {21'h00_0000, blksel_reg};
            `SRA_REG_INT_STAT: RDATA <= {29'h0000_0000, int_stat};
            `SRA_REG_INT_MASK: RDATA <= {29'h0000_0000, int_mask};
            `SRA_REG_REC_LEN: RDATA <= {16'h0000, len_reg};
            default: RDATA <= 32'h0000_0000;
         endcase
      end else begin
         RDATA <= 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // Record sequencer
   // ----------------------------------------
   assign busy = seg_reg != S_IDLE;
   assign load = busy && (!REC_VALID || REC_READY);
   assign seg_last = idx_reg == seg_len(seg_reg) - 4'd1;
   assign final_byte = seg_last && seg_after == S_IDLE;

   always @* begin
      seg_after = S_IDLE;
      ax_after = ax_reg;
      case (seg_reg)
         S_HDR, S_GEN, S_TBL, S_PLN: begin
            seg_after = next_seg(seg_reg, hdr_reg[10:0]);
            ax_after = next_axis(hdr_reg[7:0], 4'd0);
         end
         S_AXS: begin
            ax_after = next_axis(hdr_reg[7:0], ax_reg + 4'd1);
            seg_after = (ax_after == NO_AXIS) ? S_IDLE : S_AXS;
         end
         default: begin
            seg_after = S_IDLE;
         end
      endcase
   end

   // Byte currently due on the stream.
   always @* begin
      cur_byte = 8'h00;
      case (seg_reg)
         S_HDR: begin
            case (idx_reg)
               4'd0: cur_byte = hdr_reg[7:0];
               4'd1: cur_byte = hdr_reg[15:8];
               4'd2: cur_byte = len_reg[7:0];
               default: cur_byte = len_reg[15:8];
            endcase
         end
         S_GEN: cur_byte = gen_byte;
         S_PLN: cur_byte = (idx_reg == 4'd0) ? pln_word[7:0] : pln_word[15:8];
         S_AXS: cur_byte = blk_w[ax_reg[2:0]][idx_reg*8 +: 8];
         S_GEO: begin
            case (idx_reg)
               4'd0: cur_byte = NUM_AXES[7:0];
               4'd1: cur_byte = {4'h0, `SRA_GEN_BYTES};
               4'd2: cur_byte = {4'h0, `SRA_PLN_BYTES};
               default: cur_byte = {4'h0, `SRA_AXIS_BYTES};
            endcase
         end
         default: cur_byte = 8'h00;
      endcase
   end

   // Start, step and finish a record or a geometry answer.
   always @(posedge SYS_CLK) begin
      if (RST) begin
         seg_reg <= S_IDLE;
         idx_reg <= 4'd0;
         ax_reg <= 4'd0;
         hdr_reg <= 16'h0000;
         len_reg <= 16'h0000;
         REC_DATA <= 8'h00;
         REC_VALID <= 1'b0;
         REC_LAST <= 1'b0;
      end else begin
         if (REC_VALID && REC_READY) begin
            REC_VALID <= 1'b0;
            REC_LAST <= 1'b0;
         end
         if (!busy && req_wr) begin
            hdr_reg <= {1'b1, 4'h0, flags_now};
            len_reg <= rec_len(flags_now);
            seg_reg <= S_HDR;
            idx_reg <= 4'd0;
            ax_reg <= 4'd0;
         end else if (!busy && geo_wr) begin
            seg_reg <= S_GEO;
            idx_reg <= 4'd0;
         end else if (load) begin
            REC_DATA <= cur_byte;
            REC_VALID <= 1'b1;
            REC_LAST <= final_byte;
            if (seg_last) begin
               seg_reg <= seg_after;
               idx_reg <= 4'd0;
               ax_reg <= ax_after;
            end else begin
               idx_reg <= idx_reg + 4'd1;
            end
         end
      end
   end

   // ----------------------------------------
   // Interrupts
   // ----------------------------------------
   assign evt[`SRA_EV_REC] = load && final_byte && seg_reg != S_GEO;
   assign evt[`SRA_EV_GEO] = load && final_byte && seg_reg == S_GEO;
   assign evt[`SRA_EV_REFUSED] = busy && (req_wr || geo_wr);

   // Sticky events, mask and the level output.
   sra_irq #(
      .W(3)
   ) u_irq (
      .clk(SYS_CLK),
      .rst(RST),
      .evt(evt),
      .mask_wr(WR && ADDR == `SRA_REG_INT_MASK),
      .mask_data(WDATA[2:0]),
      .stat_rd(RD && ADDR == `SRA_REG_INT_STAT),
      .stat_reg(int_stat),
      .mask_reg(int_mask),
      .irq_reg(IRQ)
   );

endmodule

// ### verif/sra_top_props.sv
`timescale 1ns/100ps
`include "sra_defines.vh"

// ----------------------------------------
// Stream checker
// ----------------------------------------
module sra_top_props #(
   parameter NUM_AXES = 8
) (
   input wire SYS_CLK,
   input wire RST,
   input wire [7:0] ADDR,
   input wire [31:0] WDATA,
   input wire WR,
   input wire [7:0] REC_DATA,
   input wire REC_VALID,
   input wire REC_LAST,
   input wire REC_READY
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   reg [15:0] idx_reg;
   reg [2:0] flg_reg;
   reg [7:0] lo_reg;
   reg [7:0] hi_reg;
   reg busy_reg;
   reg geo_reg;
   wire [7:0] n_ax = NUM_AXES;
   wire beat = REC_VALID && REC_READY;
   wire go = WR && ADDR == `SRA_REG_CTRL && WDATA[1:0] != 2'h0 && !busy_reg;
   wire [15:0] s_at = 16'h4 + flg_reg[2] + (flg_reg[1] ? 16'h8 : 16'h0);
   wire [7:0] hi_w = idx_reg == 16'h3 ? REC_DATA : hi_reg;
   wire [7:0] geo_w = idx_reg == 16'h0 ? n_ax : idx_reg == 16'h1 ? 8'h1 : idx_reg == 16'h2 ? 8'h2 : 8'h9;

   // Follows the byte position and kind of the frame in flight.
   always @(posedge SYS_CLK) begin
      if (RST) begin
         idx_reg <= 16'h0;
         busy_reg <= 1'b0;
         geo_reg <= 1'b0;
      end else begin
         if (go) busy_reg <= 1'b1;
         if (go) geo_reg <= !WDATA[0];
         if (beat) idx_reg <= REC_LAST ? 16'h0 : idx_reg + 16'h1;
         if (beat && REC_LAST) busy_reg <= 1'b0;
         if (beat && idx_reg == 16'h1) flg_reg <= REC_DATA[2:0];
         if (beat && idx_reg == 16'h2) lo_reg <= REC_DATA;
         if (beat && idx_reg == 16'h3) hi_reg <= REC_DATA;
      end
   end

   sequence start_s;
      go;
   endsequence
   sequence end_s;
      beat ##0 (REC_LAST && !geo_reg);
   endsequence

   AST_HDR_FORCED: assert property (REC_VALID && !geo_reg && idx_reg == 16'h1 |-> REC_DATA[7:3] == 5'h10)
      else $error("header flag byte malformed");
   AST_LEN_MATCH: assert property (end_s |-> idx_reg + 16'h1 == {hi_w, lo_reg})
      else $error("length count differs from bytes sent");
   AST_HDR_WHOLE: assert property (end_s |-> idx_reg >= 16'h3)
      else $error("record ended inside header");
   AST_GEN_BYTE: assert property (REC_VALID && !geo_reg && flg_reg[2] && idx_reg == 16'h4 |-> REC_DATA[6:3] == 4'h0)
      else $error("general status unused bits set");
   AST_RSV_ZERO: assert property (REC_VALID && !geo_reg && flg_reg[1] && idx_reg >= 16'h4 + flg_reg[2]
      && idx_reg < s_at |-> REC_DATA == 8'h0)
      else $error("reserved block byte not zero");
   AST_PLANE_LO: assert property (REC_VALID && !geo_reg && flg_reg[0] && idx_reg == s_at |-> (REC_DATA & 8'hc7) == 8'h0)
      else $error("plane word low byte has unused bits");
   AST_PLANE_HI: assert property (REC_VALID && !geo_reg && flg_reg[0] && idx_reg == s_at + 16'h1 |-> REC_DATA[6:0] == 7'h0)
      else $error("plane word high byte has unused bits");
   AST_GEO_SHAPE: assert property (REC_VALID && geo_reg |-> REC_LAST == (idx_reg == 16'h3) && REC_DATA == geo_w)
      else $error("geometry answer wrong");
   AST_START_LAT: assert property (start_s |-> ##1 !REC_VALID ##1 REC_VALID)
      else $error("first byte not two cycles after start");
   AST_HOLD: assert property (REC_VALID && !REC_READY |=> REC_VALID && $stable(REC_DATA) && $stable(REC_LAST))
      else $error("stream byte changed while stalled");
endmodule

bind sra_top sra_top_props #(.NUM_AXES(NUM_AXES)) i_sra_top_props (.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .REC_DATA(REC_DATA), .REC_VALID(REC_VALID), .REC_LAST(REC_LAST), .REC_READY(REC_READY));

// ### verif/sra_host_model.sv
`timescale 1ns/100ps

// ----------------------------------------
// Host draining the record stream
// ----------------------------------------
module sra_host_model (
   input wire clk,
   input wire rst,
   input wire slow,
   input wire clr,
   input wire [7:0] data,
   input wire valid,
   input wire last,
   output reg ready,
   output reg done,
   output reg [15:0] rx_len
);
   logic [7:0] rx_q[$];
   reg [1:0] ph_reg;

   // Takes bytes, stalling three cycles in four when slow.
   always @(posedge clk) begin
      if (rst || clr) begin
         ready <= 1'b0;
         done <= 1'b0;
         ph_reg <= 2'h0;
         rx_q.delete();
      end else begin
         ph_reg <= ph_reg + 2'h1;
         ready <= !slow || ph_reg == 2'h3;
         if (valid && ready && rx_q.size() == 3) rx_len <= {data, rx_q[2]};
         if (valid && ready) begin
            rx_q.push_back(data);
            done <= last;
         end
      end
   end
endmodule

// ### verif/tb_sra_top.sv
`timescale 1ns/100ps
`include "sra_defines.vh"

module tb_sra_top;
   typedef struct {
      logic [10:0] blk;
      logic [15:0] w;
      logic [4:0] x;
      logic [31:0] v;
      logic [17:0] t;
      logic [15:0] len;
   } sra_row_t;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, slow = 1'b0, clr = 1'b0;
   logic [7:0] addr = 8'h0;
   logic [31:0] wdata = 32'h0, got;
   logic [3:0] gen = 4'h0, vec = 4'h0;
   logic [7:0] ax [0:20] = '{default: 8'h0};
   logic [255:0] vel = 256'h0;
   logic [143:0] tq = 144'h0;
   wire [31:0] rdata;
   wire [7:0] rec_data;
   wire rec_valid, rec_last, rec_ready, irq, done;
   wire [15:0] rx_len;
   logic [7:0] exp_q[$];
   int mismatches = 0, n_tests = 0, cyc = 0;
   sra_row_t rows [0:4] = '{'{11'h400, 16'h0085, 5'h11, 32'h0, 18'h0, 16'h5},
      '{11'h7ff, 16'ha5c3, 5'h0a, 32'h04000001, 18'h1ffff, 16'h21},
      '{11'h102, 16'h5a3c, 5'h15, 32'hfffffffe, 18'h363c0, 16'hf},
      '{11'h000, 16'hffff, 5'h1f, 32'h0, 18'h0, 16'h4},
      '{11'h201, 16'h1234, 5'h03, 32'h12, 18'h64, 16'h15}};

   sra_top #(.NUM_AXES(2)) i_sra_top (.SYS_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .REC_DATA(rec_data), .REC_VALID(rec_valid), .REC_LAST(rec_last), .REC_READY(rec_ready),
      .IRQ(irq), .PROG_RUN(gen[3]), .WAIT_INPUT(gen[2]), .TRACE_ON(gen[1]), .ECHO_ON(gen[0]),
      .VEC_MOVE(vec[3]), .VEC_SLEW(vec[2]), .VEC_STOP(vec[1]), .VEC_DECEL(vec[0]), .AX_MOVE(ax[0]),
      .AX_ABS_REL(ax[1]), .AX_ABS_ONLY(ax[2]), .AX_EDGE_SEARCH(ax[3]), .AX_HOMING(ax[4]), .AX_HOME_PH1(ax[5]),
      .AX_HOME_PH2(ax[6]), .AX_COORD(ax[7]), .AX_NEG_DIR(ax[8]), .AX_CONTOUR(ax[9]), .AX_SLEW(ax[10]),
      .AX_STOPPING(ax[11]), .AX_DECEL(ax[12]), .AX_LATCH_ARMED(ax[13]), .AX_OFF_ON_ERR(ax[14]),
      .AX_MOTOR_OFF(ax[15]), .AX_LATCHED(ax[16]), .AX_LATCH_IN(ax[17]), .AX_REV_LIMIT(ax[18]),
      .AX_HOME_IN(ax[19]), .AX_STEP_JUMPER(ax[20]), .AX_VEL(vel), .AX_TORQUE(tq));

   sra_host_model i_sra_host_model (.clk(clk), .rst(rst), .slow(slow), .clr(clr), .data(rec_data),
      .valid(rec_valid), .last(rec_last), .ready(rec_ready), .done(done), .rx_len(rx_len));

   // ----------------------------------------
   // Clock, timeout and helpers
   // ----------------------------------------
   initial forever #4 clk = ~clk;

   // Cuts a hung run short.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         wrap_up;
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   function automatic logic [15:0] clampw(input logic [17:0] t);
      if ($signed(t) > 18'sh7fff) return 16'h7fff;
      if ($signed(t) < -18'sh7fff) return 16'h8001;
      return t[15:0];
   endfunction

   task automatic put(input logic [31:0] v, input int n);
      for (int k = 0; k < n; k++) exp_q.push_back(v[8*k+:8]);
   endtask

   // Drives axis 0 with the row and axis 1 with its complement, its velocity plus one and its torque negated.
   task apply(input sra_row_t r);
      int k;
      @(posedge clk);
      for (k = 0; k < 16; k++) ax[k] <= {6'h0, ~r.w[15-k], r.w[15-k]};
      for (k = 0; k < 5; k++) ax[16+k] <= {6'h0, ~r.x[4-k], r.x[4-k]};
      vel <= {192'h0, r.v + 32'h1, r.v};
      tq <= {108'h0, -r.t, r.t};
      gen <= r.w[3:0];
      vec <= r.w[7:4];
   endtask

   // Builds the expected record; axes above the second are dropped.
   task automatic build(input sra_row_t r);
      logic [10:0] b;
      b = r.blk & 11'h703;
      exp_q.delete();
      put({r.len, 5'h10, b[10:8], b[7:0]}, 4);
      if (b[10]) put({r.w[3], 4'h0, r.w[2:0]}, 1);
      if (b[9]) put(32'h0, 4);
      if (b[9]) put(32'h0, 4);
      if (b[8]) put({r.w[7], 9'h0, r.w[6:4], 3'h0}, 2);
      for (int a = 0; a < 2; a++) begin
         if (b[a]) begin
            put(a ? ~r.w : r.w, 2);
            put(a ? {~r.x[4:3], 3'h0, ~r.x[2:0]} : {r.x[4:3], 3'h0, r.x[2:0]}, 1);
            put((r.v + a) << 6, 4);
            put(clampw(a ? -r.t : r.t), 2);
         end
      end
   endtask

   // Starts a request, optionally sends a geometry request while busy, and compares the bytes.
   task automatic run(input logic [31:0] cmd, input logic dup);
      int n;
      logic [31:0] b;
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      bus_wr(`SRA_REG_CTRL, cmd);
      if (dup) bus_wr(`SRA_REG_CTRL, 32'h2);
      if (dup) begin
         bus_rd(`SRA_REG_CTRL, b);
         check(b, 32'h1);
      end
      n = 0;
      while (done !== 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
      #1;
      check(done, 32'h1);
      check(i_sra_host_model.rx_q.size(), exp_q.size());
      for (int k = 0; k < exp_q.size(); k++) check(i_sra_host_model.rx_q[k], exp_q[k]);
      repeat (2) @(posedge clk);
      #1;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         apply(rows[i]);
         slow <= i[0];
         bus_wr(`SRA_REG_BLKSEL, {21'h0, rows[i].blk});
         build(rows[i]);
         run(32'h1, 1'b0);
         check(rx_len, rows[i].len);
      end
      // Second reset, then defaults and an unmapped place.
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      check({rdata[29:0], rec_valid, irq}, 32'h0);
      bus_rd(`SRA_REG_BLKSEL, got);
      check(got, 32'h7ff);
      bus_wr(8'h20, 32'hffffffff);
      bus_rd(8'h20, got);
      check(got, 32'h0);
      // Record done interrupt with the default block select.
      bus_wr(`SRA_REG_INT_MASK, 32'h1);
      apply(rows[1]);
      build(rows[1]);
      run(32'h3, 1'b0);
      check(irq, 32'h1);
      bus_rd(`SRA_REG_INT_STAT, got);
      check(got, 32'h1);
      repeat (2) @(posedge clk);
      #1;
      check(irq, 32'h0);
      // Geometry answer with its event masked.
      exp_q.delete();
      put({8'h9, 8'h2, 8'h1, 8'h2}, 4);
      run(32'h2, 1'b0);
      check(irq, 32'h0);
      bus_rd(`SRA_REG_INT_STAT, got);
      check(got, 32'h2);
      // Request refused while busy, host stalling.
      bus_wr(`SRA_REG_INT_MASK, 32'h4);
      slow <= 1'b1;
      build(rows[1]);
      run(32'h1, 1'b1);
      check(irq, 32'h1);
      bus_rd(`SRA_REG_REC_LEN, got);
      check(got, 32'h21);
      bus_rd(`SRA_REG_INT_STAT, got);
      check(got, 32'h5);
      wrap_up;
   end
endmodule
